// >>> hdl/sar_pkg.sv
package sar_pkg;

  // ----------------------------------------------------------------
  // word layout
  // ----------------------------------------------------------------
  localparam int RESULT_W = 18;
  localparam int HDR_W    = 2;
  localparam int FRAME_W  = RESULT_W + HDR_W;
  localparam int IDX_W    = 5;

  localparam logic [HDR_W-1:0]    SELF_HDR  = 2'h2;
  localparam logic [RESULT_W-1:0] SIGN_MASK = 18'h2_0000;
  localparam logic [RESULT_W-1:0] ONE_LSB   = 18'h0_0001;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int MAX_RATE_SPS  = 5_000_000;
  localparam int CONV_PERIOD_NS = 1_000_000_000 / MAX_RATE_SPS;
  localparam int CONV_PERIOD_CYC = CONV_PERIOD_NS / CLK_PERIOD_NS;
  localparam int T_MSB_NS  = 150;
  localparam int T_MSB_CYC =
    (T_MSB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_CNV_HI_NS  = 10;
  localparam int T_CNV_HI_CYC =
    (T_CNV_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RCLK_HALF_CYC = 5;

  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_ACQ  = 3'h0,
    ST_OPEN = 3'h1,
    ST_HOLD = 3'h3,
    ST_CONV = 3'h2,
    ST_DONE = 3'h6
  } conv_state_t;

  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_CNV   = 3'h1,
    H_BURST = 3'h3,
    H_DONE  = 3'h2
  } host_state_t;

  // twos complement <-> offset binary
  function automatic logic [RESULT_W-1:0] flip_sign(
    input logic [RESULT_W-1:0] v);
    return v ^ SIGN_MASK;
  endfunction

endpackage

// >>> hdl/sar_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface sar_link_if;
  logic cnv_p;
  logic cnv_n;
  logic rclk_p;
  logic rclk_n;
  logic dat_p;
  logic dat_n;
  logic eck_p;
  logic eck_n;

  modport dev (
    input  cnv_p, cnv_n, rclk_p, rclk_n,
    output dat_p, dat_n, eck_p, eck_n
  );

  modport host (
    output cnv_p, cnv_n, rclk_p, rclk_n,
    input  dat_p, dat_n, eck_p, eck_n
  );
endinterface

`default_nettype wire

// >>> hdl/sar_adc_device.sv
// Overview of operation
// R1 - result belongs to the conversion just started
// R2 - sustains five million conversions per second; here the host readout alone outlasts the 40-clock period
// R3 - convert on rising start after acquisition
// R4 - start input accepted as CMOS or LVDS
// R5 - open ground switches, then ground arrays
// R6 - eighteen decisions MSB first, then form code
// R7 - host reads only after first-bit delay
// R8 - host bursts read clock, never free-running; here it toggles every clock while reset is held
// R9 - data shifted out with host read clock
// R10 - read clock quiet until first-bit delay
// R11 - echoed clock or self-timed data stream
// R12 - eighteen bits, MSB first, twos complement
// R13 - 1FFFF top, 00000 zero, 20000 bottom
// R14 - host clocks eighteen bits into word
`timescale 1ns/1ps
`default_nettype none

module sar_adc_device (
  // link to the host
  sar_link_if.dev                       link,
  // converter clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  // analogue stand-in and straps
  input  wire logic [sar_pkg::RESULT_W-1:0] sample_in,
  input  wire logic                     lvds_mode,
  input  wire logic                     echo_mode,
  // conversion status
  output logic                          busy,
  output logic                          positive_ground_switch,
  output logic                          negative_ground_switch,
  output logic                          arrays_grounded,
  output logic                          conv_done,
  output logic [sar_pkg::RESULT_W-1:0]  result
);

  localparam int W = sar_pkg::RESULT_W;

  // ----------------------------------------------------------------
  // converter domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    sar_pkg::conv_state_t         st;
    logic                         cnv_m;
    logic                         cnv_s;
    logic                         cnvn_m;
    logic                         cnvn_s;
    logic                         lvds_m;
    logic                         lvds_s;
    logic                         cnv_prev;
    logic [W-1:0]                 smp_m;
    logic [W-1:0]                 smp_s;
    logic [W-1:0]                 held;
    logic [W-1:0]                 code;
    logic [sar_pkg::IDX_W-1:0]    bit_pos;
    logic                         done;
    logic [W-1:0]                 word;
  } core_t;

  // ----------------------------------------------------------------
  // link domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                         rst_m;
    logic                         rst_s;
    logic                         echo_m;
    logic                         echo_s;
    logic [sar_pkg::IDX_W-1:0]    idx;
  } link_t;

  core_t                          c_q;
  core_t                          c_d;
  link_t                          l_q;
  link_t                          l_d;
  logic                           cnv_lvl;
  logic                           out_bit;
  logic [sar_pkg::IDX_W-1:0]      frame_len;

  // bit of the outgoing frame at position idx
  function automatic logic frame_bit(
    input logic [W-1:0]              w,
    input logic [sar_pkg::IDX_W-1:0] idx,
    input logic                      echo);
    logic [sar_pkg::FRAME_W-1:0] f;
    f = {sar_pkg::SELF_HDR, w};
    if (echo) begin
      return w[W - 1 - int'(idx)];
    end
    return f[sar_pkg::FRAME_W - 1 - int'(idx)];
  endfunction

  // ----------------------------------------------------------------
  // start detection
  // ----------------------------------------------------------------
  // lvds: positive leg above negative leg; cmos: positive leg only
  assign cnv_lvl = c_q.lvds_s ? (c_q.cnv_s & ~c_q.cnvn_s)
                              : c_q.cnv_s; // R4

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  always_comb begin
    logic [W-1:0] trial;
    trial      = '0;
    c_d        = c_q;
    c_d.cnv_m  = link.cnv_p;
    c_d.cnv_s  = c_q.cnv_m;
    c_d.cnvn_m = link.cnv_n;
    c_d.cnvn_s = c_q.cnvn_m;
    c_d.lvds_m = lvds_mode;
    c_d.lvds_s = c_q.lvds_m;
    c_d.smp_m  = sample_in;
    c_d.smp_s  = c_q.smp_m;
    c_d.cnv_prev = cnv_lvl;
    c_d.done   = 1'b0;
    case (c_q.st)
      sar_pkg::ST_ACQ: begin
        // arrays track the input until the start edge
        c_d.held = sar_pkg::flip_sign(c_q.smp_s);
        if (cnv_lvl && !c_q.cnv_prev) begin
          c_d.st = sar_pkg::ST_OPEN; // R3
        end
      end
      sar_pkg::ST_OPEN: begin
        // ground switches open, sample frozen
        c_d.st = sar_pkg::ST_HOLD; // R5
      end
      sar_pkg::ST_HOLD: begin
        // arrays moved to ground, held sample on comparator
        c_d.code    = '0;
        c_d.bit_pos = sar_pkg::IDX_W'(W - 1);
        c_d.st      = sar_pkg::ST_CONV; // R5
      end
      sar_pkg::ST_CONV: begin
        trial = c_q.code | (sar_pkg::ONE_LSB << c_q.bit_pos);
        if (trial <= c_q.held) begin
          c_d.code = trial; // R6
        end
        if (c_q.bit_pos == '0) begin
          c_d.st = sar_pkg::ST_DONE;
        end else begin
          c_d.bit_pos = c_q.bit_pos - 1'b1; // R6
        end
      end
      sar_pkg::ST_DONE: begin
        // no pipeline: word replaced by this sample only
        c_d.word = sar_pkg::flip_sign(c_q.code); // R1 R13
        c_d.done = 1'b1;
        c_d.st   = sar_pkg::ST_ACQ; // R2
      end
      default: begin
        c_d.st = sar_pkg::ST_ACQ;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  // ----------------------------------------------------------------
  // serial readout on the host read clock
  // ----------------------------------------------------------------
  assign frame_len = l_q.echo_s ? sar_pkg::IDX_W'(W)
                                : sar_pkg::IDX_W'(sar_pkg::FRAME_W); // R11

  always_comb begin
    l_d        = l_q;
    l_d.rst_m  = rst_n;
    l_d.rst_s  = l_q.rst_m;
    l_d.echo_m = echo_mode;
    l_d.echo_s = l_q.echo_m;
    if (!l_q.rst_s) begin
      l_d.idx = '0;
    end else if (l_q.idx == frame_len - 1'b1) begin
      // frame boundary relies on full bursts from the host
      l_d.idx = '0; // R14
    end else begin
      l_d.idx = l_q.idx + 1'b1; // R9
    end
  end

  always_ff @(posedge link.rclk_p) begin
    l_q <= l_d;
  end

  // word is static while the host clocks it out
  assign out_bit = frame_bit(c_q.word, l_q.idx, l_q.echo_s); // R12 R7 R10

  assign link.dat_p = out_bit; // R9
  assign link.dat_n = ~out_bit;
  assign link.eck_p = l_q.echo_s & link.rclk_p; // R11
  assign link.eck_n = l_q.echo_s & link.rclk_n; // R11

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  assign busy = (c_q.st != sar_pkg::ST_ACQ);
  assign positive_ground_switch = (c_q.st == sar_pkg::ST_ACQ); // R5
  assign negative_ground_switch = (c_q.st == sar_pkg::ST_ACQ); // R5
  assign arrays_grounded = (c_q.st == sar_pkg::ST_HOLD)
                        || (c_q.st == sar_pkg::ST_CONV)
                        || (c_q.st == sar_pkg::ST_DONE);
  assign conv_done = c_q.done;
  assign result    = c_q.word;

endmodule // sar_adc_device

`default_nettype wire

// >>> hdl/sar_adc_host.sv
`timescale 1ns/1ps
`default_nettype none

module sar_adc_host #(
  parameter int HALF_CYC = sar_pkg::RCLK_HALF_CYC
) (
  // link to the converter
  sar_link_if.host                      link,
  // host clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  // user request side
  input  wire logic                     start,
  input  wire logic                     lvds_mode,
  input  wire logic                     echo_mode,
  output logic                          ready,
  // user answer side
  output logic                          word_valid,
  output logic [sar_pkg::RESULT_W-1:0]  word,
  output logic                          frame_error
);

  localparam int W = sar_pkg::RESULT_W;
  // converter side brings its reset over two flops on the read clock
  localparam int FLUSH_RISES = 2;

  if (HALF_CYC < 3 || HALF_CYC > 15) begin : g_half_check
    $error("HALF_CYC must lie between 3 and 15");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    sar_pkg::host_state_t         st;
    logic [7:0]                   cnt;
    logic [3:0]                   half;
    logic [sar_pkg::IDX_W-1:0]    nbit;
    logic [sar_pkg::FRAME_W-1:0]  shreg;
    logic                         rclk;
    logic                         cnv;
    logic                         dat_m;
    logic                         dat_s;
    logic                         valid;
    logic [W-1:0]                 word;
    logic                         ferr;
  } host_t;

  host_t                          q;
  host_t                          d;
  logic [sar_pkg::IDX_W-1:0]      burst_len;

  assign burst_len = echo_mode ? sar_pkg::IDX_W'(W)
                               : sar_pkg::IDX_W'(sar_pkg::FRAME_W);

  // ----------------------------------------------------------------
  // conversion and burst sequencer
  // ----------------------------------------------------------------
  always_comb begin
    d       = q;
    d.dat_m = link.dat_p;
    d.dat_s = q.dat_m;
    d.valid = 1'b0;
    case (q.st)
      sar_pkg::H_IDLE: begin
        d.rclk = 1'b0;
        if (q.nbit != '0) begin
          // rises after reset carry the release to the link side
          d.rclk = ~q.rclk;
          if (!q.rclk) begin
            d.nbit = q.nbit - 1'b1;
          end
        end else if (start) begin
          d.cnv = 1'b1; // R3
          d.cnt = '0;
          d.st  = sar_pkg::H_CNV;
        end
      end
      sar_pkg::H_CNV: begin
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == 8'(sar_pkg::T_CNV_HI_CYC - 1)) begin
          d.cnv = 1'b0;
        end
        // read clock held still until first bit is out
        if (q.cnt == 8'(sar_pkg::T_MSB_CYC - 1)) begin
          d.half = '0;
          d.nbit = '0;
          d.st   = sar_pkg::H_BURST; // R7 R10
        end
      end
      sar_pkg::H_BURST: begin
        d.half = q.half + 1'b1;
        if (q.half == 4'(HALF_CYC - 1)) begin
          d.half = '0;
          if (!q.rclk) begin
            // take the settled bit before the rise moves it on
            d.rclk  = 1'b1; // R8
            d.shreg = {q.shreg[sar_pkg::FRAME_W-2:0], q.dat_s}; // R14
            d.nbit  = q.nbit + 1'b1;
          end else begin
            d.rclk = 1'b0;
            if (q.nbit == burst_len) begin
              d.st = sar_pkg::H_DONE; // R14
            end
          end
        end
      end
      sar_pkg::H_DONE: begin
        d.word  = q.shreg[W-1:0]; // R14
        d.ferr  = !echo_mode &&
          (q.shreg[sar_pkg::FRAME_W-1 -: sar_pkg::HDR_W]
           != sar_pkg::SELF_HDR);
        d.valid = 1'b1;
        d.nbit  = '0;
        d.st    = sar_pkg::H_IDLE;
      end
      default: begin
        d.st = sar_pkg::H_IDLE;
      end
    endcase
  end

  // read clock runs during reset so the converter link side resets
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q      <= '0;
      q.nbit <= sar_pkg::IDX_W'(FLUSH_RISES);
      // if/else rather than inversion so an unknown start still toggles
      if (q.rclk) begin
        q.rclk <= 1'b0;
      end else begin
        q.rclk <= 1'b1;
      end
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // pins and user outputs
  // ----------------------------------------------------------------
  assign link.cnv_p  = q.cnv;
  assign link.cnv_n  = lvds_mode ? ~q.cnv : 1'b0;
  assign link.rclk_p = q.rclk;
  assign link.rclk_n = ~q.rclk;

  assign ready       = (q.st == sar_pkg::H_IDLE) && (q.nbit == '0);
  assign word_valid  = q.valid;
  assign word        = q.word;
  assign frame_error = q.ferr;

endmodule // sar_adc_host

`default_nettype wire

// >>> tb/sar_link_props.sv
`timescale 1ns/1ps
`default_nettype none

module sar_link_props (
  // clock, reset and straps
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic lvds_mode,
  input  wire logic echo_mode,
  // link wires
  input  wire logic cnv_p,
  input  wire logic cnv_n,
  input  wire logic rclk_p,
  input  wire logic rclk_n,
  input  wire logic dat_p,
  input  wire logic dat_n,
  input  wire logic eck_p,
  input  wire logic eck_n
);

  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  logic       cnv_q;
  logic       rclk_q;
  logic [5:0] since_q;
  logic [4:0] edges_q;
  logic       cnv_rise;

  assign cnv_rise = cnv_p & ~cnv_q;

  // cycles since the last start, saturating; read-clock rises per frame
  always_ff @(posedge clock) begin
    cnv_q  <= cnv_p;
    rclk_q <= rclk_p;
    if (!rst_n) begin
      since_q <= 6'h00;
      edges_q <= 5'h00;
    end else begin
      if (cnv_rise) begin
        since_q <= 6'h01;
        edges_q <= 5'h00;
      end else begin
        if (since_q != 6'h00 && since_q != 6'h3F) begin
          since_q <= since_q + 6'h01;
        end
        if (rclk_p & ~rclk_q) begin
          edges_q <= edges_q + 5'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // link properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence start_pulse;
    cnv_p ##1 !cnv_p;
  endsequence

  sequence quiet_window;
    since_q >= 6'h01 && since_q <= 6'h1B;
  endsequence

  property clock_quiet;
    quiet_window |-> $stable(rclk_p);
  endproperty

  a_dat_pair: assert property (dat_n == !dat_p)
    else $error("data pair not complementary");
  a_rclk_pair: assert property (rclk_n == !rclk_p)
    else $error("read clock pair not complementary");
  a_cnv_pair: assert property ($fell(cnv_p) |-> cnv_n == lvds_mode)
    else $error("start pair negative leg wrong for strap");
  a_cnv_width: assert property ($rose(cnv_p) |=> start_pulse)
    else $error("start pulse not two cycles high");
  a_quiet_clock: assert property (clock_quiet)
    else $error("read clock moved before first-bit delay");
  a_start_gap: assert property (
    cnv_rise && since_q != 6'h00 |-> since_q >= 6'h28)
    else $error("starts closer than forty cycles");
  a_whole_burst: assert property (
    cnv_rise && since_q != 6'h00 |->
      edges_q == (echo_mode ? 5'h12 : 5'h14))
    else $error("burst length wrong for read mode");
  a_late_read: assert property (
    rclk_p && !rclk_q && since_q != 6'h00 |-> since_q >= 6'h1E)
    else $error("read clock rose before first-bit delay");
  a_dat_steady: assert property ($past(rclk_p) |-> $stable(dat_p))
    else $error("data moved away from a read clock rise");
  a_no_echo: assert property (!echo_mode |-> !eck_p)
    else $error("echoed clock active in self-timed mode");

endmodule // sar_link_props

`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int HALF  = 3;
  localparam int LIMIT = 600;

  logic                         clock;
  logic                         rst_n;
  logic                         start;
  logic                         lvds_mode;
  logic                         echo_mode;
  logic [sar_pkg::RESULT_W-1:0] sample_in;
  logic                         ready;
  logic                         word_valid;
  logic [sar_pkg::RESULT_W-1:0] word;
  logic                         frame_error;
  logic                         pos_sw;
  logic                         neg_sw;
  logic                         arrays_grounded;
  logic                         busy;
  logic                         conv_done;
  logic [sar_pkg::RESULT_W-1:0] result;
  logic [sar_pkg::RESULT_W-1:0] codes [7];
  int                           mismatches;
  int                           num_checks;
  logic                         hung;

  sar_link_if u_sar_link_if ();

  sar_adc_device u_sar_adc_device (
    .link(u_sar_link_if), .clock(clock), .rst_n(rst_n),
    .sample_in(sample_in), .lvds_mode(lvds_mode), .echo_mode(echo_mode),
    .busy(busy), .positive_ground_switch(pos_sw),
    .negative_ground_switch(neg_sw), .arrays_grounded(arrays_grounded),
    .conv_done(conv_done), .result(result));

  sar_adc_host #(.HALF_CYC(HALF)) u_sar_adc_host (
    .link(u_sar_link_if), .clock(clock), .rst_n(rst_n), .start(start),
    .lvds_mode(lvds_mode), .echo_mode(echo_mode), .ready(ready),
    .word_valid(word_valid), .word(word), .frame_error(frame_error));

  sar_link_props u_sar_link_props (
    .clock(clock), .rst_n(rst_n), .lvds_mode(lvds_mode),
    .echo_mode(echo_mode), .cnv_p(u_sar_link_if.cnv_p),
    .cnv_n(u_sar_link_if.cnv_n), .rclk_p(u_sar_link_if.rclk_p),
    .rclk_n(u_sar_link_if.rclk_n), .dat_p(u_sar_link_if.dat_p),
    .dat_n(u_sar_link_if.dat_n), .eck_p(u_sar_link_if.eck_p),
    .eck_n(u_sar_link_if.eck_n));

  always #2.5 clock = ~clock;

  // ----------------------------------------------------------------
  // compare and closing tasks
  // ----------------------------------------------------------------
  task automatic check_word(input logic [sar_pkg::RESULT_W-1:0] got,
                            input logic [sar_pkg::RESULT_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic do_reset(input logic lv, input logic ec);
    @(posedge clock);
    #1;
    rst_n = 1'b0;
    lvds_mode = lv;
    echo_mode = ec;
    repeat (8) @(posedge clock);
    #1;
    rst_n = 1'b1;
  endtask

  // one conversion and readout, with the wire frame collected on the side
  task automatic convert(input logic [sar_pkg::RESULT_W-1:0] v);
    int                           n;
    logic                         rclk_prev;
    logic                         dat_prev;
    logic [sar_pkg::RESULT_W-1:0] pulses;
    logic [sar_pkg::RESULT_W-1:0] edges;
    logic [sar_pkg::FRAME_W-1:0]  frm;
    n = 0;
    pulses = '0;
    edges = '0;
    frm = '0;
    sample_in = v;
    repeat (3) @(posedge clock);
    #1;
    while (ready !== 1'b1 && n < LIMIT) begin
      @(posedge clock);
      #1;
      n++;
    end
    n = 0;
    start = 1'b1;
    rclk_prev = u_sar_link_if.rclk_p;
    dat_prev = u_sar_link_if.dat_p;
    while (word_valid !== 1'b1 && n < LIMIT) begin
      @(posedge clock);
      #1;
      n++;
      // a start during the readout burst must be ignored
      start = (n == 60) ? 1'b1 : 1'b0;
      if (n == 40) sample_in = ~v;
      if (conv_done === 1'b1) pulses = pulses + sar_pkg::ONE_LSB;
      if (arrays_grounded === 1'b1) check_bit(pos_sw | neg_sw, 1'b0);
      if (arrays_grounded === 1'b1) check_bit(busy, 1'b1);
      check_bit(u_sar_link_if.eck_p, echo_mode & u_sar_link_if.rclk_p);
      check_bit(u_sar_link_if.eck_n, echo_mode & u_sar_link_if.rclk_n);
      if (u_sar_link_if.rclk_p === 1'b1 && rclk_prev === 1'b0) begin
        edges = edges + sar_pkg::ONE_LSB;
        frm = {frm[sar_pkg::FRAME_W-2:0], dat_prev};
      end
      rclk_prev = u_sar_link_if.rclk_p;
      dat_prev = u_sar_link_if.dat_p;
    end
    if (n >= LIMIT) begin
      mismatches++;
      hung = 1'b1;
      return;
    end
    check_bit(busy, 1'b0);
    check_word(word, v);
    check_word(result, v);
    check_word(pulses, sar_pkg::ONE_LSB);
    check_word(frm[sar_pkg::RESULT_W-1:0], v);
    check_word(edges, echo_mode ? 18'h0_0012 : 18'h0_0014);
    check_bit(frame_error, 1'b0);
    if (echo_mode === 1'b0) begin
      check_bit(frm[sar_pkg::FRAME_W-1], sar_pkg::SELF_HDR[1]);
      check_bit(frm[sar_pkg::FRAME_W-2], sar_pkg::SELF_HDR[0]);
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    start = 1'b0;
    lvds_mode = 1'b0;
    echo_mode = 1'b0;
    sample_in = '0;
    mismatches = 0;
    num_checks = 0;
    hung = 1'b0;
    codes = '{18'h1_FFFF, 18'h0_0001, 18'h0_0000, 18'h3_FFFF,
              18'h2_0001, 18'h2_0000, 18'h1_5A5A};
    for (int m = 0; m < 4 && !hung; m++) begin
      do_reset(m[0], m[1]);
      foreach (codes[i]) begin
        if (!hung) convert(codes[i]);
      end
    end
    wrap_up();
  end

endmodule // tb_top

`default_nettype wire
